// ### rtl/ahf_pkg.sv
// shared constants, types and helpers of the ascii hex command framer host
package ahf_pkg;

    localparam logic [7:0] CHAR_CR = 8'h0d;
    localparam logic [7:0] CHAR_0 = 8'h30;
    localparam logic [7:0] CHAR_9 = 8'h39;
    localparam logic [7:0] CHAR_A = 8'h41;
    localparam logic [7:0] CHAR_F = 8'h46;
    localparam logic [3:0] NIB_TEN = 4'ha;

    // request header is seq, cmd, selector, index, len hi, len lo
    localparam logic [3:0] REQ_HDR_LAST = 4'h5;
    localparam logic [3:0] CHK_LAST = 4'h1;
    // reply header is seq, code, len hi, len lo; two check bytes follow
    localparam logic [15:0] RSP_POS_SEQ = 16'h0000;
    localparam logic [15:0] RSP_POS_CODE = 16'h0001;
    localparam logic [15:0] RSP_POS_LENH = 16'h0002;
    localparam logic [15:0] RSP_POS_LENL = 16'h0003;
    localparam logic [15:0] RSP_HDR_BYTES = 16'h0004;
    localparam logic [16:0] RSP_OVERHEAD = 17'h00006;

    localparam logic [7:0] RSP_NAK = 8'h00;
    localparam logic [7:0] RSP_ACK_FINAL = 8'h01;
    localparam logic [7:0] RSP_ACK_INTERIM = 8'h02;

    localparam logic [15:0] CRC_POLY_DFLT = 16'h1021;
    localparam logic [15:0] CRC_INIT_DFLT = 16'hffff;

    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned TIMEOUT_US = 100000;
    localparam int unsigned TIMEOUT_CYC_DFLT = TIMEOUT_US * CLK_MHZ;
    localparam logic [3:0] MAX_RETRY_DFLT = 4'h3;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned FIFO_AW = 4;

    localparam logic [1:0] ST_FINAL = 2'h0;
    localparam logic [1:0] ST_INTERIM = 2'h1;
    localparam logic [1:0] ST_TIMEOUT = 2'h2;

    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] item_selector;
        logic [7:0] item_index;
        logic [15:0] len;
    } ahf_req_s;

    typedef struct packed {
        logic [7:0] seq;
        logic [7:0] code;
        logic [15:0] len;
        logic [1:0] status;
    } ahf_rsp_s;

    typedef enum logic [2:0] {
        T_IDLE, T_HDR, T_PAY, T_CHK, T_END, T_WAIT
    } ahf_tx_e;

    typedef enum logic {R_BODY, R_JUNK} ahf_rx_e;

    // nibble to its upper-case hex character
    function automatic logic [7:0] hex_char(input logic [3:0] n);
        if (n < NIB_TEN) begin
            return CHAR_0 + {4'h0, n};
        end
        return CHAR_A + {4'h0, n - NIB_TEN};
    endfunction

    // character to {legal, nibble}; lower case is illegal
    function automatic logic [4:0] hex_val(input logic [7:0] c);
        logic [7:0] d;
        d = 8'h00;
        if (c >= CHAR_0 && c <= CHAR_9) begin
            d = c - CHAR_0;
            return {1'b1, d[3:0]};
        end
        if (c >= CHAR_A && c <= CHAR_F) begin
            d = c - CHAR_A;
            return {1'b1, d[3:0] + NIB_TEN};
        end
        return 5'h00;
    endfunction

    // one byte through the msb-first check register, no final inversion
    function automatic logic [15:0] crc_step(input logic [15:0] crc,
                                             input logic [7:0] b,
                                             input logic [15:0] poly);
        logic [15:0] c;
        c = crc ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) begin
            c = c[15] ? ((c << 1) ^ poly) : (c << 1);
        end
        return c;
    endfunction

endpackage

// ### rtl/ahf_fifo.sv
// payload fifo with a replay mark so a request can be resent
`timescale 1ns/100ps
`default_nettype none
module ahf_fifo #(
    parameter int unsigned W = 8,
    parameter int unsigned DEPTH = 16,
    parameter int unsigned AW = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready,
    input wire logic commit,
    input wire logic rewind
);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wr_ff, rd_ff, base_ff;
    logic [AW:0] nxt_wr, nxt_rd, nxt_base;
    logic in_ready_ff;
    logic [W-1:0] out_data_ff;
    logic push, pop;

    // popped words stay held until commit; space frees only then
    assign push = in_valid && in_ready_ff;
    assign pop = out_ready && out_valid;
    assign out_valid = rd_ff != wr_ff;
    assign out_data = out_data_ff;
    assign in_ready = in_ready_ff;

    always_comb begin
        nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
        nxt_rd = rewind ? base_ff : (pop ? rd_ff + 1'b1 : rd_ff);
        nxt_base = commit ? rd_ff : base_ff;
    end

    // pointers and a registered ready so back-pressure is glitch free
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_ff <= '0;
            rd_ff <= '0;
            base_ff <= '0;
            in_ready_ff <= 1'b0;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            base_ff <= nxt_base;
            in_ready_ff <= (nxt_wr - nxt_base) != (AW+1)'(DEPTH);
        end
    end

    // storage write; read word registered from the next read pointer,
    // bypassing a word that lands on an empty fifo so it still falls through
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ff[AW-1:0]] <= in_data;
        end
        if (push && nxt_rd == wr_ff) begin
            out_data_ff <= in_data;
        end else begin
            out_data_ff <= mem[nxt_rd[AW-1:0]];
        end
    end
endmodule
`default_nettype wire

// ### rtl/ahf_host.sv
// host end of the ascii hex command link: framing, retry and reply check
`timescale 1ns/100ps
`default_nettype none
module ahf_host #(
    parameter logic [15:0] CRC_POLY = ahf_pkg::CRC_POLY_DFLT,
    parameter logic [15:0] CRC_INIT = ahf_pkg::CRC_INIT_DFLT,
    parameter int unsigned TIMEOUT_CYC = ahf_pkg::TIMEOUT_CYC_DFLT,
    parameter logic [3:0] MAX_RETRY = ahf_pkg::MAX_RETRY_DFLT
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic req_valid,
    input wire ahf_pkg::ahf_req_s req,
    output logic req_ready,
    input wire logic pay_in_valid,
    input wire logic [7:0] pay_in_data,
    output logic pay_in_ready,
    output logic tx_valid,
    output logic [7:0] tx_char,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire logic [7:0] rx_char,
    output logic rsp_valid,
    output ahf_pkg::ahf_rsp_s rsp,
    output logic rsp_byte_valid,
    output logic [7:0] rsp_byte
);
    ahf_pkg::ahf_tx_e state_ff, nxt_state;
    ahf_pkg::ahf_req_s req_ff;
    logic [7:0] seq_ff, tx_char_ff, cur_byte;
    logic [3:0] bidx_ff, retry_ff;
    logic [15:0] pcnt_ff, crc_ff;
    logic [31:0] timer_ff;
    logic lo_ff, tx_valid_ff, req_ready_ff, slot_free, issue, byte_done;
    logic accept, timeout, reply_hit, retry_go, fifo_valid, fifo_pop;
    logic fifo_commit, fifo_rewind;
    logic [7:0] fifo_data;
    logic rsp_valid_ff, rsp_byte_valid_ff;
    ahf_pkg::ahf_rsp_s rsp_ff;
    logic [7:0] rsp_byte_ff;

    ////////////////////////////////////////////////////////////////////
    // payload buffer; replayed from its mark on every retry
    ahf_fifo #(
        .W(8),
        .DEPTH(ahf_pkg::FIFO_DEPTH),
        .AW(ahf_pkg::FIFO_AW)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(pay_in_valid),
        .in_data(pay_in_data),
        .in_ready(pay_in_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(fifo_pop),
        .commit(fifo_commit),
        .rewind(fifo_rewind)
    );

    ////////////////////////////////////////////////////////////////////
    // transmit side: byte in flight and the character slot
    always_comb begin
        cur_byte = 8'h00;
        case (state_ff)
            ahf_pkg::T_HDR: begin
                case (bidx_ff)
                    4'h0: cur_byte = seq_ff;
                    4'h1: cur_byte = req_ff.cmd;
                    4'h2: cur_byte = req_ff.item_selector;
                    4'h3: cur_byte = req_ff.item_index;
                    4'h4: cur_byte = req_ff.len[15:8];
                    default: cur_byte = req_ff.len[7:0];
                endcase
            end
            ahf_pkg::T_PAY: cur_byte = fifo_data;
            ahf_pkg::T_CHK: begin
                cur_byte = (bidx_ff == 4'h0) ? crc_ff[15:8] : crc_ff[7:0];
            end
            default: cur_byte = 8'h00;
        endcase
    end

    assign slot_free = !tx_valid_ff || tx_ready;
    assign issue = slot_free && (state_ff == ahf_pkg::T_HDR
                   || state_ff == ahf_pkg::T_CHK
                   || state_ff == ahf_pkg::T_END
                   || (state_ff == ahf_pkg::T_PAY && fifo_valid));
    assign byte_done = issue && lo_ff && state_ff != ahf_pkg::T_END;
    assign fifo_pop = byte_done && state_ff == ahf_pkg::T_PAY;
    assign accept = req_ready_ff && req_valid;
    assign timeout = state_ff == ahf_pkg::T_WAIT && timer_ff == 32'h0;
    assign retry_go = timeout && retry_ff < MAX_RETRY;
    assign fifo_rewind = retry_go;

    ////////////////////////////////////////////////////////////////////
    // receive side state
    ahf_pkg::ahf_rx_e rstate_ff;
    logic [15:0] rpos_ff, rlen_ff, rcrc_ff;
    logic [7:0] rseq_ff, rcode_ff;
    logic [3:0] rhi_ff;
    logic rlo_ff, rx_ok_ff;
    logic [4:0] rx_hex;
    logic [7:0] rx_byte;
    logic [16:0] rx_total;

    assign rx_hex = ahf_pkg::hex_val(rx_char);
    assign rx_byte = {rhi_ff, rx_hex[3:0]};
    assign rx_total = {1'b0, rlen_ff} + ahf_pkg::RSP_OVERHEAD;
    // only a complete reply to the outstanding sequence counts
    assign reply_hit = rx_ok_ff && state_ff == ahf_pkg::T_WAIT
                       && rseq_ff == seq_ff;
    assign fifo_commit = (reply_hit
                          && rcode_ff != ahf_pkg::RSP_ACK_INTERIM)
                         || (timeout && !retry_go);

    ////////////////////////////////////////////////////////////////////
    // request sequencer
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ahf_pkg::T_IDLE: begin
                if (accept) begin
                    nxt_state = ahf_pkg::T_HDR;
                end
            end
            ahf_pkg::T_HDR: begin
                if (byte_done && bidx_ff == ahf_pkg::REQ_HDR_LAST) begin
                    // no payload means straight to the
                    nxt_state = (req_ff.len == 16'h0) ? ahf_pkg::T_CHK
                                                       : ahf_pkg::T_PAY;
                end
            end
            ahf_pkg::T_PAY: begin
                if (byte_done && pcnt_ff == req_ff.len - 16'h1) begin
                    nxt_state = ahf_pkg::T_CHK;
                end
            end
            ahf_pkg::T_CHK: begin
                if (byte_done && bidx_ff == ahf_pkg::CHK_LAST) begin
                    nxt_state = ahf_pkg::T_END;
                end
            end
            ahf_pkg::T_END: begin
                if (issue) begin
                    nxt_state = ahf_pkg::T_WAIT;
                end
            end
            ahf_pkg::T_WAIT: begin
                if (retry_go) begin
                    nxt_state = ahf_pkg::T_HDR;
                end else if (timeout || fifo_commit) begin
                    nxt_state = ahf_pkg::T_IDLE;
                end
            end
            default: nxt_state = ahf_pkg::T_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff <= ahf_pkg::T_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // request capture and sequence number; a retry keeps it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            req_ff <= '0;
            seq_ff <= 8'h00;
            retry_ff <= 4'h0;
        end else if (accept) begin
            req_ff <= req;
            seq_ff <= seq_ff + 8'h01;
            retry_ff <= 4'h0;
        end else if (retry_go) begin
            retry_ff <= retry_ff + 4'h1;
        end
    end

    // byte position, nibble phase and running check value
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bidx_ff <= 4'h0;
            pcnt_ff <= 16'h0;
            lo_ff <= 1'b0;
            crc_ff <= CRC_INIT;
        end else if (accept || retry_go) begin
            bidx_ff <= 4'h0;
            pcnt_ff <= 16'h0;
            lo_ff <= 1'b0;
            crc_ff <= CRC_INIT;
        end else if (issue && state_ff != ahf_pkg::T_END) begin
            lo_ff <= !lo_ff;
            if (byte_done) begin
                // the check bytes themselves are not folded
                if (state_ff != ahf_pkg::T_CHK) begin
                    crc_ff <= ahf_pkg::crc_step(crc_ff, cur_byte, CRC_POLY);
                end
                if (state_ff == ahf_pkg::T_PAY) begin
                    pcnt_ff <= pcnt_ff + 16'h1;
                end
                bidx_ff <= (nxt_state != state_ff) ? 4'h0
                                                   : bidx_ff + 4'h1;
            end
        end
    end

    // character slot; hex pair high nibble first, then CR
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tx_valid_ff <= 1'b0;
            tx_char_ff <= 8'h00;
        end else if (issue) begin
            tx_valid_ff <= 1'b1;
            if (state_ff == ahf_pkg::T_END) begin
                tx_char_ff <= ahf_pkg::CHAR_CR;
            end else begin
                tx_char_ff <= ahf_pkg::hex_char(lo_ff ? cur_byte[3:0]
                                                      : cur_byte[7:4]);
            end
        end else if (tx_ready) begin
            tx_valid_ff <= 1'b0;
        end
    end

    // reply timer; an interim reply restarts the wait
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            timer_ff <= 32'h0;
        end else if ((state_ff == ahf_pkg::T_END && issue) || reply_hit) begin
            timer_ff <= 32'(TIMEOUT_CYC - 1);
        end else if (timer_ff != 32'h0) begin
            timer_ff <= timer_ff - 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // reply parser; a CR always restarts at line start
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rstate_ff <= ahf_pkg::R_BODY;
            rpos_ff <= 16'h0;
            rlo_ff <= 1'b0;
            rhi_ff <= 4'h0;
            rcrc_ff <= CRC_INIT;
            rseq_ff <= 8'h00;
            rcode_ff <= 8'h00;
            rlen_ff <= 16'h0;
            rx_ok_ff <= 1'b0;
        end else begin
            rx_ok_ff <= 1'b0;
            if (rx_valid) begin
                if (rx_char == ahf_pkg::CHAR_CR) begin
                    // whole pairs, exact length, zero residue
                    rx_ok_ff <= rstate_ff == ahf_pkg::R_BODY && !rlo_ff
                                && rpos_ff >= ahf_pkg::RSP_HDR_BYTES
                                && {1'b0, rpos_ff} == rx_total
                                && rcrc_ff == 16'h0;
                    rstate_ff <= ahf_pkg::R_BODY;
                    rpos_ff <= 16'h0;
                    rlo_ff <= 1'b0;
                    rcrc_ff <= CRC_INIT;
                end else if (rstate_ff == ahf_pkg::R_JUNK) begin
                    rstate_ff <= ahf_pkg::R_JUNK;
                end else if (!rx_hex[4]) begin
                    rstate_ff <= ahf_pkg::R_JUNK;
                end else if (!rlo_ff) begin
                    rhi_ff <= rx_hex[3:0];
                    rlo_ff <= 1'b1;
                end else begin
                    rlo_ff <= 1'b0;
                    rcrc_ff <= ahf_pkg::crc_step(rcrc_ff, rx_byte, CRC_POLY);
                    rpos_ff <= rpos_ff + 16'h1;
                    if (rpos_ff == ahf_pkg::RSP_POS_SEQ) begin
                        rseq_ff <= rx_byte;
                    end else if (rpos_ff == ahf_pkg::RSP_POS_CODE) begin
                        rcode_ff <= rx_byte;
                    end else if (rpos_ff == ahf_pkg::RSP_POS_LENH) begin
                        rlen_ff <= {rx_byte, rlen_ff[7:0]};
                    end else if (rpos_ff == ahf_pkg::RSP_POS_LENL) begin
                        rlen_ff <= {rlen_ff[15:8], rx_byte};
                    end else if ({1'b0, rpos_ff} >= rx_total) begin
                        rstate_ff <= ahf_pkg::R_JUNK; // overlong line
                    end
                end
            end
        end
    end

    // reply bytes stream out as parsed; trust them only after rsp_valid
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rsp_byte_valid_ff <= 1'b0;
            rsp_byte_ff <= 8'h00;
        end else begin
            rsp_byte_valid_ff <= rx_valid && rx_char != ahf_pkg::CHAR_CR
                && rstate_ff == ahf_pkg::R_BODY && rx_hex[4] && rlo_ff
                && rpos_ff >= ahf_pkg::RSP_HDR_BYTES
                && {1'b0, rpos_ff} < rx_total - 17'h2;
            rsp_byte_ff <= rx_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // user reports and handshake flags
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rsp_valid_ff <= 1'b0;
            rsp_ff <= '0;
            req_ready_ff <= 1'b0;
        end else begin
            req_ready_ff <= nxt_state == ahf_pkg::T_IDLE;
            rsp_valid_ff <= reply_hit || (timeout && !retry_go);
            if (reply_hit) begin
                rsp_ff.seq <= rseq_ff;
                rsp_ff.code <= rcode_ff;
                rsp_ff.len <= rlen_ff;
                rsp_ff.status <= (rcode_ff == ahf_pkg::RSP_ACK_INTERIM)
                                 ? ahf_pkg::ST_INTERIM : ahf_pkg::ST_FINAL;
            end else if (timeout) begin
                rsp_ff.seq <= seq_ff;
                rsp_ff.status <= ahf_pkg::ST_TIMEOUT;
            end
        end
    end

    assign req_ready = req_ready_ff;
    assign tx_valid = tx_valid_ff;
    assign tx_char = tx_char_ff;
    assign rsp_valid = rsp_valid_ff;
    assign rsp = rsp_ff;
    assign rsp_byte_valid = rsp_byte_valid_ff;
    assign rsp_byte = rsp_byte_ff;

    ////////////////////////////////////////////////////////////////////
    // checks on the framing behaviour
    a_tx_char_legal: assert property (
        @(posedge clk_sys) disable iff (rst)
        tx_valid_ff |-> ahf_pkg::hex_val(tx_char_ff) != 5'h00
            || tx_char_ff == ahf_pkg::CHAR_CR)
        else $error("illegal character on transmit");
    a_cr_after_check: assert property (
        @(posedge clk_sys) disable iff (rst)
        (byte_done && state_ff == ahf_pkg::T_CHK
            && bidx_ff == ahf_pkg::CHK_LAST)
        |=> state_ff == ahf_pkg::T_END)
        else $error("check field not followed by carriage return");
    a_cr_on_end: assert property (
        @(posedge clk_sys) disable iff (rst)
        (issue && state_ff == ahf_pkg::T_END)
        |=> tx_valid_ff && tx_char_ff == ahf_pkg::CHAR_CR)
        else $error("line end slot carried no carriage return");
    a_retry_same_seq: assert property (
        @(posedge clk_sys) disable iff (rst)
        retry_go |=> state_ff == ahf_pkg::T_HDR
            && seq_ff == $past(seq_ff) ##[1:3] tx_valid_ff)
        else $error("retry changed sequence or did not restart");
    a_new_seq_step: assert property (
        @(posedge clk_sys) disable iff (rst)
        accept |=> seq_ff == $past(seq_ff) + 8'h01)
        else $error("sequence not advanced for new request");
    a_first_char_seq: assert property (
        @(posedge clk_sys) disable iff (rst)
        (issue && state_ff == ahf_pkg::T_HDR && bidx_ff == 4'h0 && !lo_ff)
        |=> tx_char_ff == ahf_pkg::hex_char(seq_ff[7:4]))
        else $error("frame does not open with sequence high nibble");
    a_pay_count: assert property (
        @(posedge clk_sys) disable iff (rst)
        (state_ff == ahf_pkg::T_PAY && nxt_state == ahf_pkg::T_CHK)
        |=> pcnt_ff == req_ff.len)
        else $error("payload byte count differs from length field");
    a_zero_len_skip: assert property (
        @(posedge clk_sys) disable iff (rst)
        (state_ff == ahf_pkg::T_HDR && req_ff.len == 16'h0)
        |=> state_ff != ahf_pkg::T_PAY)
        else $error("payload phase entered with zero length");
    a_reply_residue: assert property (
        @(posedge clk_sys) disable iff (rst)
        rx_ok_ff |-> $past(rcrc_ff) == 16'h0 && $past(!rlo_ff))
        else $error("reply accepted with nonzero check residue");
    a_lower_rejected: assert property (
        @(posedge clk_sys) disable iff (rst)
        (rx_valid && rx_char != ahf_pkg::CHAR_CR && !rx_hex[4])
        |=> rstate_ff == ahf_pkg::R_JUNK ##0 !rx_ok_ff)
        else $error("illegal reply character not discarded");
endmodule
`default_nettype wire

// ### tb/ahf_dev_model.sv
// behavioural device: judges request lines and sends echo replies
`timescale 1ns/100ps
`default_nettype none
module ahf_dev_model (
    input wire logic clk_sys,
    input wire logic tx_valid,
    input wire logic [7:0] tx_char,
    output logic tx_ready = 1'b1,
    output logic rx_valid = 1'b0,
    output logic [7:0] rx_char = 8'h00,
    input wire logic [1:0] mode,
    output logic [7:0] n_good = 8'h00
);
    logic [7:0] b[$], rp[$], q[$];
    logic [7:0] last_seq = 8'h00;
    logic [15:0] c16;
    logic [3:0] hi, nb;
    logic odd = 1'b0, bad = 1'b0;
    ////////////////////////////////////////////////////////////////////////
    // check over binary bytes, msb first, so a good line leaves zero
    function automatic logic [15:0] crc(input logic [7:0] d[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (d[i]) begin
            c = c ^ {d[i], 8'h00};
            for (int k = 0; k < 8; k++) begin
                c = c[15] ? (c << 1) ^ 16'h1021 : c << 1;
            end
        end
        return c;
    endfunction
    function automatic logic [7:0] hx(input logic [3:0] n);
        return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
    endfunction
    // whole line judged at the CR; a malformed one gets no reply at all
    task automatic line_end;
        if (!bad && !odd && b.size() >= 8 && crc(b) == 16'h0000 &&
            b.size() == 8 + {b[4], b[5]}) begin
            n_good = n_good + 8'h01;
            // one-byte ack only; no naks, interims, baud or string checks
            // are modelled
            if (b[0] != last_seq) begin
                rp = '{b[0], 8'h01, 8'h00, 8'h01, b[1]};
                c16 = crc(rp);
                rp.push_back(c16[15:8]);
                rp.push_back(c16[7:0]);
                last_seq = b[0];
            end
            foreach (rp[i]) q = {q, hx(rp[i][7:4]), hx(rp[i][3:0])};
            // mode 2 spoils the last check digit, on even counts with a
            // lower-case letter, so the host must drop either line
            if (mode == 2'h2) begin
                q[q.size()-1] = n_good[0] ? hx(c16[3:0] ^ 4'h1) : 8'h66;
            end
            q.push_back(8'h0d);
        end
        b.delete();
        bad = 1'b0;
        odd = 1'b0;
    endtask
    // mode 1 drops ready on every other cycle to exercise backpressure
    always @(posedge clk_sys) begin
        tx_ready <= (mode != 2'h1) || !tx_ready;
        if (tx_valid && tx_ready && tx_char == 8'h0d) begin
            line_end();
        end else if (tx_valid && tx_ready) begin
            bad = bad || !(tx_char inside {[8'h30:8'h39], [8'h41:8'h46]});
            nb = tx_char[6] ? tx_char[3:0] + 4'h9 : tx_char[3:0];
            if (odd) b.push_back({hi, nb});
            hi = nb;
            odd = !odd;
        end
    end
    // idle line inverts every bit each cycle, alternating between the last character and its complement
    always @(posedge clk_sys) begin
        rx_valid <= q.size() > 0;
        rx_char <= (q.size() > 0) ? q.pop_front() : ~rx_char;
    end
endmodule
`default_nettype wire

// ### tb/ahf_host_bench.sv
// self-checking bench of the host framer against the device model
`timescale 1ns/100ps
`default_nettype none
module ahf_host_bench;
    logic clk_sys = 1'b0, rst = 1'b1, req_valid = 1'b0, pay_in_valid = 1'b0;
    logic [7:0] pay_in_data = 8'h00, got_byte = 8'h00;
    logic [1:0] mode = 2'h0;
    ahf_pkg::ahf_req_s req = '0;
    ahf_pkg::ahf_rsp_s rsp;
    logic req_ready, pay_in_ready, tx_valid, tx_ready, rx_valid;
    logic rsp_valid, rsp_byte_valid;
    logic [7:0] tx_char, rx_char, rsp_byte, n_good;
    int err_count = 0, n_checks = 0;
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (rsp_byte_valid) got_byte <= rsp_byte;
    // short timeout and one retry keep the resend path quick to reach
    ahf_host #(.TIMEOUT_CYC(200), .MAX_RETRY(4'h1)) ahf_host_i (.clk_sys,
        .rst, .req_valid, .req, .req_ready, .pay_in_valid, .pay_in_data,
        .pay_in_ready, .tx_valid, .tx_char, .tx_ready, .rx_valid, .rx_char,
        .rsp_valid, .rsp, .rsp_byte_valid, .rsp_byte);
    ahf_dev_model ahf_dev_model_i (.clk_sys, .tx_valid, .tx_char, .tx_ready,
        .rx_valid, .rx_char, .mode, .n_good);
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] g, e);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic push(input int n);
        for (int i = 0; i < n; i++) begin
            pay_in_valid = 1'b1;
            pay_in_data = 8'ha0 + 8'(i);
            @(posedge clk_sys);
            while (!pay_in_ready) @(posedge clk_sys);
            #1;
        end
        pay_in_valid = 1'b0;
    endtask
    task automatic send(input logic [7:0] c, input logic [15:0] n);
        req = '{cmd: c, item_selector: 8'h00, item_index: 8'h00, len: n};
        req_valid = 1'b1;
        @(posedge clk_sys);
        while (!req_ready) @(posedge clk_sys);
        #1;
        req_valid = 1'b0;
        chk("req_ready", req_ready, 16'h0000);
        for (int k = 0; k < 3000 && rsp_valid !== 1'b1; k++) tick();
        chk("rsp_valid", rsp_valid, 16'h0001);
    endtask
    // fifo filled to refusal, then a full-length request on a stalling line
    task automatic t_full;
        mode = 2'h1;
        push(16);
        tick();
        chk("pay_in_ready", pay_in_ready, 16'h0000);
        send(8'h5a, 16'h0010);
        chk("seq", rsp.seq, 16'h0001);
        chk("code", rsp.code, ahf_pkg::RSP_ACK_FINAL);
        chk("len", rsp.len, 16'h0001);
        chk("byte", got_byte, 16'h005a);
        chk("good", n_good, 16'h0001);
    endtask
    // spoiled replies are dropped, the frame resent, then a timeout report
    task automatic t_retry;
        mode = 2'h2;
        push(1);
        send(8'h33, 16'h0001);
        chk("status", rsp.status, ahf_pkg::ST_TIMEOUT);
        chk("seq", rsp.seq, 16'h0002);
        chk("resent", n_good, 16'h0003);
    endtask
    // a request with no payload goes straight from header to check
    task automatic t_empty;
        mode = 2'h0;
        send(8'hc3, 16'h0000);
        chk("seq", rsp.seq, 16'h0003);
        chk("status", rsp.status, ahf_pkg::ST_FINAL);
        chk("len", rsp.len, 16'h0001);
        chk("byte", got_byte, 16'h00c3);
        chk("good", n_good, 16'h0004);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        tick();
        tick();
        t_full();
        t_retry();
        t_empty();
        close_out();
    end
    // some 40000 cycles, far beyond the few hundred the tests need
    initial begin
        #200000;
        err_count++;
        close_out();
    end
endmodule
`default_nettype wire
